/* File: include/scd_pkg.sv */
// scd_pkg: offsets, field positions, reset values and timing of the serial
// calibration and debug register bank.
// assumes a 10 MHz core clock and a 32-bit Avalon-MM register port.
`default_nettype none
package scd_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_LOOPBACK    = 12'h42c;
    localparam logic [11:0] IDX_CAL_CTRL    = 12'h42e;
    localparam logic [11:0] IDX_FORCE_VAL   = 12'h42f;
    localparam logic [11:0] IDX_FORCE_CTRL  = 12'h41e;
    localparam logic [11:0] IDX_IRQ_STATUS  = 12'h4f0;
    localparam logic [11:0] IDX_IRQ_MASK    = 12'h4f1;
    localparam logic [15:0] REG_RESET       = 16'h0000;
    // field positions
    localparam int LB_EN_BIT      = 4;
    localparam int WD_DIS_BIT     = 11;
    localparam int WD_SEL_LSB     = 9;
    localparam int AVG_LSB        = 7;
    localparam int DO_CAL_BIT     = 6;
    localparam int CDR_LOCK_BIT   = 5;
    localparam int SYNC_BIT       = 0;
    localparam int FORCE_EN_BIT   = 8;
    localparam int FV_ELOST_BIT   = 2;
    localparam int FV_EDET_BIT    = 1;
    localparam int FV_SLEEP_BIT   = 0;
    localparam logic [15:0] CAL_RW_MASK = 16'h0f9e;
    // interrupt status bits
    localparam int IRQ_CAL_DONE   = 0;
    localparam int IRQ_CAL_TMO    = 1;
    localparam int IRQ_LOCK_CHG   = 2;
    localparam int IRQ_W          = 3;
    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int WD_32_NS       = 32000;
    localparam int WD_48_NS       = 48000;
    localparam int WD_64_NS       = 64000;
    localparam int WD_128_NS      = 128000;
    localparam int WD_CNT_W       = 11;
    localparam logic [WD_CNT_W-1:0] WD_32_CYC  = WD_CNT_W'(WD_32_NS / CLK_PERIOD_NS);
    localparam logic [WD_CNT_W-1:0] WD_48_CYC  = WD_CNT_W'(WD_48_NS / CLK_PERIOD_NS);
    localparam logic [WD_CNT_W-1:0] WD_64_CYC  = WD_CNT_W'(WD_64_NS / CLK_PERIOD_NS);
    localparam logic [WD_CNT_W-1:0] WD_128_CYC = WD_CNT_W'(WD_128_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01
    } scd_cal_state_type;
endpackage : scd_pkg
`default_nettype wire

/* File: hw/scd_regs.sv */
// scd_regs: serial-link loopback, calibration sequencer with watchdog and
// averaging, clock-recovery status and energy/sleep force control.
// assumes Avalon-MM master on mclk_in; analog status inputs are asynchronous;
// transmit and receive data are on mclk_in.
// Operation
// (RL1) loopback bit routes tx into rx internally
// (RL2) watchdog expiry stops calibration, applies default
// (RL3) watchdog disable bit lets calibration finish
// (RL4) timeout select: 32, 48, 64, 128 us
// (RL5) averaging select: 1, 2, 4, 8 runs
// (RL6) start bit launches calibration, self-clears
// (RL7) read-only clock-recovery lock bit, zero after reset
// (RL8) energy-lost indication force value bit
// (RL9) energy detector enable force value bit
// (RL10) sleep force value, gated by force enable
// (RL11) finish only after all repetitions or timeout
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scd_regs
    import scd_pkg::*;
#(
    parameter int DATA_W = 10
) (
    // clock, reset, enable
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    // avalon-mm slave
    input  wire logic [13:0]       avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic [31:0]            avs_readdata_out,
    output logic                   avs_waitrequest_out,
    output logic                   irq_out,
    // serial datapath
    input  wire logic [DATA_W-1:0] tx_data_in,
    input  wire logic [DATA_W-1:0] pad_rx_data_in,
    output logic [DATA_W-1:0]      rx_data_out,
    // calibration engine
    output logic                   cal_step_start_out,
    input  wire logic              cal_step_done_in,
    output logic                   cal_active_out,
    output logic                   cal_use_default_out,
    // analog status
    input  wire logic              clock_recovery_lock_in,
    input  wire logic              receive_data_sync_status_in,
    // energy and sleep control
    input  wire logic              energy_lost_indication_in,
    input  wire logic              energy_detector_enable_in,
    input  wire logic              sleep_enable_in,
    output logic                   energy_lost_indication_out,
    output logic                   energy_detector_enable_out,
    output logic                   sleep_enable_out
);

    function automatic logic [WD_CNT_W-1:0] wd_limit_f(input logic [1:0] sel);
        case (sel)
            2'b00:   wd_limit_f = WD_32_CYC;
            2'b01:   wd_limit_f = WD_48_CYC;
            2'b10:   wd_limit_f = WD_64_CYC;
            default: wd_limit_f = WD_128_CYC;
        endcase
    endfunction : wd_limit_f

    function automatic logic [15:0] merge_f(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge_f = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge_f

    logic [15:0]         loopback_r;
    logic [15:0]         cal_ctrl_r;
    logic [15:0]         force_val_r;
    logic                force_en_r;
    logic [IRQ_W-1:0]    irq_status_r;
    logic [IRQ_W-1:0]    irq_mask_r;
    logic                ack_r;
    logic [31:0]         rdata_r;
    logic [2:0]          lock_sync_r;
    logic [1:0]          dsync_sync_r;
    logic [3:0]          done_sync_r;
    logic [1:0]          elost_sync_r;
    logic [1:0]          edet_sync_r;
    logic [1:0]          sleep_sync_r;
    scd_cal_state_type   cal_state_r;
    logic [2:0]          rep_cnt_r;
    logic [WD_CNT_W-1:0] wd_cnt_r;

    logic [11:0]         idx;
    logic                req;
    logic                wr_acc;
    logic                rd_acc;
    logic [15:0]         wr_cal;
    logic                start_cal;
    logic                step_done;
    logic [2:0]          reps_last;
    logic [WD_CNT_W-1:0] wd_limit;
    logic                evt_timeout;
    logic                evt_done;
    logic                lock_chg;
    logic [IRQ_W-1:0]    irq_evt;
    logic [15:0]         rd_word;

    // one wait cycle per access keeps read data registered
    assign idx                 = avs_address_in[13:2];
    assign req                 = avs_read_in | avs_write_in;
    // writes land on the edge that ends the wait, the one the master sees
    assign avs_waitrequest_out = req & ~(ack_r & ce_in);
    assign wr_acc              = ce_in & avs_write_in & ack_r;
    assign rd_acc              = ce_in & avs_read_in & ~ack_r;
    assign wr_cal              = merge_f(cal_ctrl_r, avs_writedata_in, avs_byteenable_in);
    assign start_cal           = wr_acc && idx == IDX_CAL_CTRL && avs_byteenable_in[0]
                                 && avs_writedata_in[DO_CAL_BIT];                   // [RL6]
    assign step_done           = done_sync_r[2] & ~done_sync_r[3];
    assign reps_last           = 3'((4'h1 << cal_ctrl_r[AVG_LSB +: 2]) - 4'h1);     // [RL5]
    assign wd_limit            = wd_limit_f(cal_ctrl_r[WD_SEL_LSB +: 2]);           // [RL4]
    assign evt_timeout         = ce_in && cal_state_r == CAL_RUN && !cal_ctrl_r[WD_DIS_BIT]
                                 && wd_cnt_r == wd_limit - 1'b1;                    // [RL2] [RL3]
    assign evt_done            = ce_in && cal_state_r == CAL_RUN && !evt_timeout && step_done
                                 && rep_cnt_r == reps_last;                         // [RL11]
    assign lock_chg            = ce_in & (lock_sync_r[2] ^ lock_sync_r[1]);
    assign irq_evt             = {lock_chg, evt_timeout, evt_done};
    assign irq_out             = |(irq_status_r & irq_mask_r);

    // ack toggles so every request sees exactly one wait cycle
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
        end else if (ce_in) begin
            ack_r <= req & ~ack_r;
        end
    end

    always_comb begin
        rd_word = 16'h0000;
        case (idx)
            IDX_LOOPBACK:   rd_word = loopback_r;
            IDX_CAL_CTRL:   rd_word = (cal_ctrl_r & CAL_RW_MASK)
                                      | (16'(lock_sync_r[2]) << CDR_LOCK_BIT)       // [RL7]
                                      | (16'(dsync_sync_r[1]) << SYNC_BIT);
            IDX_FORCE_VAL:  rd_word = force_val_r;
            IDX_FORCE_CTRL: rd_word = 16'(force_en_r) << FORCE_EN_BIT;
            IDX_IRQ_STATUS: rd_word = 16'(irq_status_r);
            IDX_IRQ_MASK:   rd_word = 16'(irq_mask_r);
            default:        rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_acc) begin
            rdata_r <= {16'h0000, rd_word};
        end
    end
    assign avs_readdata_out = rdata_r;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            loopback_r  <= REG_RESET;
            cal_ctrl_r  <= REG_RESET;
            force_val_r <= REG_RESET;
            force_en_r  <= 1'b0;
            irq_mask_r  <= '0;
        end else if (wr_acc) begin
            case (idx)
                IDX_LOOPBACK:   loopback_r  <= merge_f(loopback_r, avs_writedata_in,
                                                       avs_byteenable_in);
                IDX_CAL_CTRL:   cal_ctrl_r  <= wr_cal & CAL_RW_MASK;                // [RL6]
                IDX_FORCE_VAL:  force_val_r <= merge_f(force_val_r, avs_writedata_in,
                                                       avs_byteenable_in);          // [RL8] [RL9]
                IDX_FORCE_CTRL: if (avs_byteenable_in[1]) begin
                    force_en_r <= avs_writedata_in[FORCE_EN_BIT];
                end
                IDX_IRQ_MASK:   if (avs_byteenable_in[0]) begin
                    irq_mask_r <= avs_writedata_in[IRQ_W-1:0];
                end
                default:        ;
            endcase
        end
    end

    // write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            irq_status_r <= '0;
        end else if (ce_in) begin
            if (wr_acc && idx == IDX_IRQ_STATUS && avs_byteenable_in[0]) begin
                irq_status_r <= (irq_status_r & ~avs_writedata_in[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_status_r <= irq_status_r | irq_evt;
            end
        end
    end

    // asynchronous analog levels, two flops before use, three for the lock readback and the step-done edge
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            lock_sync_r  <= 3'b000;
            dsync_sync_r <= 2'b00;
            done_sync_r  <= 4'b0000;
            elost_sync_r <= 2'b00;
            edet_sync_r  <= 2'b00;
            sleep_sync_r <= 2'b00;
        end else if (ce_in) begin
            lock_sync_r  <= {lock_sync_r[1:0], clock_recovery_lock_in};
            dsync_sync_r <= {dsync_sync_r[0], receive_data_sync_status_in};
            done_sync_r  <= {done_sync_r[2:0], cal_step_done_in};
            elost_sync_r <= {elost_sync_r[0], energy_lost_indication_in};
            edet_sync_r  <= {edet_sync_r[0], energy_detector_enable_in};
            sleep_sync_r <= {sleep_sync_r[0], sleep_enable_in};
        end
    end

    // loop sits ahead of the pads, so the mac sees its own data
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rx_data_out <= '0;
        end else if (ce_in) begin
            rx_data_out <= loopback_r[LB_EN_BIT] ? tx_data_in : pad_rx_data_in;     // [RL1]
        end
    end

    // forced values override the detector only while force enable is set
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            energy_lost_indication_out <= 1'b0;
            energy_detector_enable_out <= 1'b0;
            sleep_enable_out           <= 1'b0;
        end else if (ce_in) begin
            energy_lost_indication_out <= force_en_r ? force_val_r[FV_ELOST_BIT]
                                                     : elost_sync_r[1];             // [RL8]
            energy_detector_enable_out <= force_en_r ? force_val_r[FV_EDET_BIT]
                                                     : edet_sync_r[1];              // [RL9]
            sleep_enable_out           <= force_en_r ? force_val_r[FV_SLEEP_BIT]
                                                     : sleep_sync_r[1];             // [RL10]
        end
    end

    // start while running is ignored; repetitions restart only by a new command
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cal_state_r         <= CAL_IDLE;
            rep_cnt_r           <= 3'h0;
            wd_cnt_r            <= '0;
            cal_step_start_out  <= 1'b0;
            cal_use_default_out <= 1'b0;
        end else if (ce_in) begin
            cal_step_start_out <= 1'b0;
            case (cal_state_r)
                CAL_IDLE: begin
                    if (start_cal) begin                                            // [RL6]
                        cal_state_r        <= CAL_RUN;
                        rep_cnt_r          <= 3'h0;
                        wd_cnt_r           <= '0;
                        cal_step_start_out <= 1'b1;
                    end
                end
                CAL_RUN: begin
                    wd_cnt_r <= wd_cnt_r + 1'b1;
                    if (evt_timeout) begin
                        cal_state_r         <= CAL_IDLE;                            // [RL2]
                        cal_use_default_out <= 1'b1;
                    end else if (step_done) begin
                        if (rep_cnt_r == reps_last) begin
                            cal_state_r         <= CAL_IDLE;                        // [RL11]
                            cal_use_default_out <= 1'b0;
                        end else begin
                            rep_cnt_r          <= rep_cnt_r + 1'b1;                 // [RL5]
                            cal_step_start_out <= 1'b1;
                        end
                    end
                end
                default: cal_state_r <= CAL_IDLE;
            endcase
        end
    end
    assign cal_active_out = cal_state_r == CAL_RUN;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_loopback;
        ce_in && loopback_r[LB_EN_BIT] |=> rx_data_out == $past(tx_data_in);
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback data mismatch"); // [RL1]

    property p_wd_expire;
        evt_timeout |=> cal_state_r == CAL_IDLE && cal_use_default_out;
    endproperty
    a_wd_expire: assert property (p_wd_expire) else $error("timeout did not stop"); // [RL2]

    property p_wd_disabled;
        cal_ctrl_r[WD_DIS_BIT] && cal_active_out && !step_done |=> cal_active_out;
    endproperty
    a_wd_disabled: assert property (p_wd_disabled) else $error("disabled watchdog fired"); // [RL3]

    property p_wd_limit;
        evt_timeout |-> (cal_ctrl_r[WD_SEL_LSB +: 2] != 2'b11 || wd_cnt_r == 11'd1279)
                        && (cal_ctrl_r[WD_SEL_LSB +: 2] != 2'b00 || wd_cnt_r == 11'd319);
    endproperty
    a_wd_limit: assert property (p_wd_limit) else $error("watchdog limit wrong");   // [RL4]

    property p_avg_count;
        evt_done |-> (cal_ctrl_r[AVG_LSB +: 2] != 2'b11 || rep_cnt_r == 3'd7)
                     && (cal_ctrl_r[AVG_LSB +: 2] != 2'b00 || rep_cnt_r == 3'd0);
    endproperty
    a_avg_count: assert property (p_avg_count) // [RL5] [RL11]
        else $error("repetition count wrong");

    property p_start;
        start_cal && cal_state_r == CAL_IDLE |=> cal_active_out && cal_step_start_out
                                                 ##1 !cal_step_start_out;
    endproperty
    a_start: assert property (p_start) else $error("start did not launch");         // [RL6]

    property p_start_self_clear;
        rd_acc && idx == IDX_CAL_CTRL
            |=> !avs_readdata_out[DO_CAL_BIT]
                && avs_readdata_out[CDR_LOCK_BIT] == $past(lock_sync_r[2]);
    endproperty
    a_start_self_clear: assert property (p_start_self_clear) // [RL6] [RL7]
        else $error("bad cal readback");

    property p_force_sleep;
        ce_in && force_en_r |=> sleep_enable_out == $past(force_val_r[FV_SLEEP_BIT])
                               && energy_lost_indication_out == $past(force_val_r[FV_ELOST_BIT]);
    endproperty
    a_force_sleep: assert property (p_force_sleep) // [RL8] [RL10]
        else $error("force value ignored");

    property p_no_force;
        ce_in && !force_en_r |=> energy_detector_enable_out == $past(edet_sync_r[1]);
    endproperty
    a_no_force: assert property (p_no_force) else $error("unforced enable wrong");  // [RL9]

    c_cal_done:  cover property (evt_done);
    c_cal_tmo:   cover property (evt_timeout);
    c_loop_on:   cover property (loopback_r[LB_EN_BIT] && ce_in);
    c_irq:       cover property (irq_out);

endmodule : scd_regs
`default_nettype wire

/* File: tb/scd_cal_model.sv */
// scd_cal_model: offset-tune engine beside the calibration sequencer.
// assumes start pulses on mclk_in; answers after delay_in cycles unless hang_in.
`timescale 1ns/1ps
`default_nettype none
module scd_cal_model (
    // clock and control
    input  wire logic        mclk_in,
    input  wire logic        hang_in,
    input  wire logic [10:0] delay_in,
    // engine handshake
    input  wire logic        cal_step_start_in,
    output logic             cal_step_done_out,
    output logic [7:0]       pulses_out
);
    int         cnt_r  = -1;
    logic       done_r = 1'b0;
    logic [7:0] pls_r  = 8'h00;
    assign cal_step_done_out = done_r;
    assign pulses_out        = pls_r;
    // done held 4 cycles so the three-flop synchroniser sees its edge
    always @(posedge mclk_in) begin
        if (cal_step_start_in === 1'b1) begin
            pls_r <= pls_r + 8'h01;
            cnt_r <= hang_in ? -1 : int'(delay_in) + 4;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
        end
        done_r <= (cnt_r > 0 && cnt_r <= 4);
    end
endmodule : scd_cal_model
`default_nettype wire

/* File: tb/tb_scd_regs.sv */
// tb_scd_regs: register, loopback, calibration, interrupt and force tests.
// assumes scd_regs answers each Avalon-MM access after one wait cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_scd_regs
    import scd_pkg::*;
;
    logic        mclk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [13:0] avs_address_in = 14'h0000;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        irq_out;
    logic [9:0]  tx_data_in = 10'h2a5;
    logic [9:0]  pad_rx_data_in = 10'h15a;
    logic [9:0]  rx_data_out;
    logic        start_w, done_w, active_w, dflt_w;
    logic        lock_in = 1'b0;
    logic        sync_in = 1'b0;
    logic [2:0]  ein = 3'b101;
    logic [2:0]  eout;
    logic        hang = 1'b0;
    logic [10:0] dly = 11'h014;
    logic [7:0]  pulses;
    logic [15:0] d;
    logic [7:0]  p0;
    int          bad_count = 0;
    int          checks = 0;
    int          n;
    localparam logic [11:0] MAP [6] = '{IDX_LOOPBACK, IDX_CAL_CTRL, IDX_FORCE_VAL,
                                        IDX_FORCE_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    localparam int LIM [4] = '{320, 480, 640, 1280};

    scd_regs u_scd_regs (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'h3), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
        .tx_data_in(tx_data_in), .pad_rx_data_in(pad_rx_data_in), .rx_data_out(rx_data_out),
        .cal_step_start_out(start_w), .cal_step_done_in(done_w), .cal_active_out(active_w),
        .cal_use_default_out(dflt_w), .clock_recovery_lock_in(lock_in),
        .receive_data_sync_status_in(sync_in), .energy_lost_indication_in(ein[2]),
        .energy_detector_enable_in(ein[1]), .sleep_enable_in(ein[0]),
        .energy_lost_indication_out(eout[2]), .energy_detector_enable_out(eout[1]),
        .sleep_enable_out(eout[0]));

    scd_cal_model u_scd_cal_model (.mclk_in(mclk_in), .hang_in(hang), .delay_in(dly),
        .cal_step_start_in(start_w), .cal_step_done_out(done_w), .pulses_out(pulses));

    initial begin
        forever #50 mclk_in = ~mclk_in;
    end

    task automatic bus(input logic we, input logic [11:0] idx, input logic [15:0] wd);
        int k;
        k = 0;
        @(posedge mclk_in);
        avs_address_in <= {idx, 2'b00};
        avs_write_in <= we;
        avs_read_in <= !we;
        avs_writedata_in <= {16'h0000, wd};
        // request held until waitrequest is seen low, then taken at that edge
        do begin
            @(posedge mclk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 50);
        d = avs_readdata_out[15:0];
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (k >= 50) bad_count++;
    endtask : bus

    task automatic wr(input logic [11:0] idx, input logic [15:0] wd);
        bus(1'b1, idx, wd);
    endtask : wr

    task automatic rd(input logic [11:0] idx);
        bus(1'b0, idx, 16'h0000);
    endtask : rd

    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (active_w !== 1'b0 && n < 3000);
        if (n >= 3000) bad_count++;
    endtask : wait_idle

    task automatic end_of_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // full run is under 8000 cycles
    initial begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        foreach (MAP[i]) begin
            rd(MAP[i]);
            `CHK(d, REG_RESET)
        end
        $display("test reset done");
        wr(IDX_LOOPBACK, 16'hffff);
        rd(IDX_LOOPBACK);
        `CHK(d, 16'hffff)
        wr(IDX_FORCE_VAL, 16'hffff);
        rd(IDX_FORCE_VAL);
        `CHK(d, 16'hffff)
        wr(IDX_CAL_CTRL, 16'hffbf);
        rd(IDX_CAL_CTRL);
        `CHK(d, CAL_RW_MASK)
        wr(12'h430, 16'hffff);
        rd(12'h430);
        `CHK(d, 16'h0000)
        wr(IDX_CAL_CTRL, 16'h0000);
        wr(IDX_FORCE_VAL, 16'h0000);
        wr(IDX_LOOPBACK, 16'h0000);
        repeat (3) @(posedge mclk_in);
        `CHK(rx_data_out, pad_rx_data_in)
        wr(IDX_LOOPBACK, 16'h0010);
        tx_data_in <= 10'h0f0;
        repeat (3) @(posedge mclk_in);
        `CHK(rx_data_out, 10'h0f0)
        wr(IDX_LOOPBACK, 16'h0000);
        $display("test regs and loopback done");
        for (int c = 0; c < 4; c++) begin
            p0 = pulses;
            wr(IDX_CAL_CTRL, 16'h0840 | 16'(c << 7));
            rd(IDX_CAL_CTRL);
            `CHK(d[DO_CAL_BIT], 1'b0)
            wait_idle();
            `CHK(8'(pulses - p0), 8'(1 << c))
            `CHK(dflt_w, 1'b0)
        end
        rd(IDX_IRQ_STATUS);
        `CHK(d[IRQ_CAL_DONE], 1'b1)
        wr(IDX_IRQ_MASK, 16'h0001);
        @(posedge mclk_in);
        `CHK(irq_out, 1'b1)
        wr(IDX_IRQ_MASK, 16'h0000);
        @(posedge mclk_in);
        `CHK(irq_out, 1'b0)
        wr(IDX_IRQ_MASK, 16'h0001);
        wr(IDX_IRQ_STATUS, 16'h0007);
        @(posedge mclk_in);
        `CHK(irq_out, 1'b0)
        $display("test averaging and irq done");
        hang <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(IDX_CAL_CTRL, 16'h0040 | 16'(c << 9));
            wait_idle();
            `CHK((n > LIM[c] - 6 && n < LIM[c] + 4), 1'b1)
            `CHK(dflt_w, 1'b1)
        end
        rd(IDX_IRQ_STATUS);
        `CHK(d[IRQ_CAL_TMO], 1'b1)
        wr(IDX_IRQ_STATUS, 16'h0007);
        hang <= 1'b0;
        dly <= 11'd500;
        p0 = pulses;
        wr(IDX_CAL_CTRL, 16'h0840);
        repeat (100) @(posedge mclk_in);
        wr(IDX_CAL_CTRL, 16'h0840);
        wait_idle();
        `CHK(8'(pulses - p0), 8'h01)
        `CHK(dflt_w, 1'b0)
        $display("test watchdog done");
        lock_in <= 1'b1;
        sync_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        `CHK(eout, 3'b101)
        rd(IDX_CAL_CTRL);
        `CHK({d[CDR_LOCK_BIT], d[SYNC_BIT]}, 2'b11)
        rd(IDX_IRQ_STATUS);
        `CHK(d[IRQ_LOCK_CHG], 1'b1)
        wr(IDX_FORCE_VAL, 16'h0002);
        repeat (4) @(posedge mclk_in);
        `CHK(eout, 3'b101)
        wr(IDX_FORCE_CTRL, 16'h0100);
        repeat (4) @(posedge mclk_in);
        `CHK(eout, 3'b010)
        $display("test force done");
        end_of_test();
    end
endmodule : tb_scd_regs
`default_nettype wire
